// file: src/srs_ref_selector.sv
// reference selector and phase alignment for subtending operation
`timescale 1ns/1ps
`include "srs_map.svh"
// Contract
// RULE_01: subtending mode takes only standard composite inputs as references.
// RULE_02: japan mode takes only japan inputs; outputs align to 4 kHz clock.
// RULE_03: non-composite inputs are monitored only, never chosen as reference.
// RULE_04: choose highest priority valid composite input as active reference.
// RULE_05: on loss switch by priority; outputs follow the new reference.
// RULE_06: all invalid: hold last alignment, frequency from holdover values.
// RULE_07: on recovery after total loss realign outputs at once.
// RULE_08: input invalid when in loss of signal or bad violation rate.
// RULE_09: loss of signal when the 64 kHz clock cannot be tracked.
// RULE_10: violation rate bad when off nominal 8000/s by over 10 percent.
// RULE_11: phase alignment signal derived from selected input violations.
// RULE_12: selected input yields 4 kHz alignment clock for output units.
// RULE_13: phase against local oscillator steers frequency and holdover value.
// RULE_14: warn when secondary violation alignment differs from the selected.
// RULE_15: a valid composite input must be present when subtending starts.
// RULE_16: both manual and automatic reference selection are supported.
// RULE_17: repeated switching must not accumulate phase or frequency error.
// RULE_18: both clock units failed: bypass the reference input to outputs.
// RULE_19: mode command sets normal, sub or japan; empty command only reports.
// RULE_20: phase step sync takes 1 to 10 steps of 100 ns, default one.
// RULE_21: sync only in subtending mode; interrupt offers stay or leave.
// RULE_22: mode changes may cause a momentary output phase transient.
module srs_ref_selector #(
    parameter int N_IN   = 2,               // composite inputs, 0 = top prio
    parameter int CLK_HZ = `SRS_CLK_HZ      // core clock rate
) (
    input  wire logic            core_clk_in,     // core clock, 100 MHz
    input  wire logic            rst_in,          // sync reset, active high
    input  wire logic [N_IN-1:0] cc_in,           // composite clock pins
    input  wire logic [N_IN-1:0] bpv_in,          // violation marker pins
    input  wire logic [N_IN-1:0] is_japan_in,     // input is japan type
    input  wire logic            ds1_in,          // monitor-only input pin
    input  wire logic            mode_cmd_in,     // mode command pulse
    input  wire logic            mode_arg_in,     // command carries argument
    input  srs_pkg::srs_mode_t   mode_val_in,     // requested mode
    input  wire logic            manual_in,       // manual selection
    input  wire logic [7:0]      manual_sel_in,   // manual input index
    input  wire logic [1:0]      clk_unit_ok_in,  // clock units healthy
    input  wire logic [15:0]     osc_phase_in,    // local oscillator phase
    input  wire logic            sync_cmd_in,     // phase step sync pulse
    input  wire logic [3:0]      sync_steps_in,   // 0 = default one step
    input  wire logic            sync_abort_in,   // interrupt request
    input  wire logic            sync_stay_in,    // stay after interrupt
    output srs_pkg::srs_mode_t   mode_out,        // present mode
    output logic                 mode_rpt_out,    // mode report pulse
    output logic                 mode_rej_out,    // start refused, pulse
    output logic [7:0]           sel_out,         // active reference index
    output logic                 ref_ok_out,      // a reference is active
    output srs_pkg::srs_src_t    src_out,         // locked/holdover/bypass
    output logic                 align_out,       // phase alignment pulse
    output logic                 clk4k_out,       // 4 kHz alignment clock
    output logic                 bypass_clk_out,  // reference passed through
    output logic signed [16:0]   freq_err_out,    // phase error to loop
    output logic signed [16:0]   holdover_out,    // learned holdover value
    output logic                 phase_warn_out,  // references misaligned
    output logic                 ds1_mon_out,     // ds1 activity seen
    output logic                 sync_busy_out,   // sync in progress
    output logic                 sync_ask_out,    // stay/leave prompt
    output logic                 step_pulse_out,  // one 100 ns step pulse
    output logic                 sync_rej_out,    // sync refused, pulse
    output logic [15:0]          offset_ns_out    // oscillator offset, ns
);
    typedef enum logic [1:0] {
        SRS_SY_IDLE,
        SRS_SY_STEP,
        SRS_SY_ASK
    } srs_sync_st_t;

    logic [N_IN-1:0] val_w;
    logic [N_IN-1:0] evt_w;
    logic [15:0]     ph_w [N_IN];
    logic [N_IN-1:0] elig_w;
    logic [N_IN-1:0] ok_w;

    srs_pkg::srs_mode_t mode_r;
    logic [7:0]      sel_r;
    logic            ref_ok_r;
    logic            was_lost_r;
    logic            align_r;
    logic            c4k_r;
    logic signed [16:0] ferr_r;
    logic signed [16:0] hold_r;
    logic            warn_r;
    logic            rpt_r;
    logic            rej_r;
    logic [2:0]      ds_s_r;
    logic            ds_r;
    srs_sync_st_t    sy_r;
    logic [3:0]      sy_left_r;
    logic            step_r;
    logic            srej_r;
    logic [15:0]     off_r;

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_mon
            srs_input_mon #(.CLK_HZ(CLK_HZ)) u_mon (
                .core_clk_in  (core_clk_in),
                .rst_in       (rst_in),
                .cc_in        (cc_in[gi]),
                .bpv_in       (bpv_in[gi]),
                .valid_out    (val_w[gi]),
                .los_out      (),
                .bpv_bad_out  (),
                .bpv_evt_out  (evt_w[gi]),
                .bpv_phase_out(ph_w[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // candidate selection
    // ****************************************************************
    wire is_sub = (mode_r != srs_pkg::SRS_MODE_NORMAL);
    assign elig_w = (mode_r == srs_pkg::SRS_MODE_JAPAN) ? is_japan_in
                  : ~is_japan_in;                           // RULE_01 RULE_02
    assign ok_w   = is_sub ? (val_w & elig_w) : val_w;      // RULE_03

    function automatic logic [8:0] pick_first(input logic [N_IN-1:0] v);
        logic [8:0] r;
        r = 9'h000;
        for (int i = N_IN - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 8'(i)};
            end
        end
        return r;
    endfunction : pick_first

    wire [8:0] auto_pick = pick_first(ok_w);                // RULE_04
    wire       man_ok    = (manual_sel_in < 8'(N_IN)) &&
                           ok_w[manual_sel_in[$clog2(N_IN)-1:0]];
    // a manual pick that goes invalid falls back to priority order
    wire [8:0] pick      = (manual_in && man_ok) ? {1'b1, manual_sel_in}
                         : auto_pick;                       // RULE_16
    wire       sync_lock = (sy_r != SRS_SY_IDLE);
    wire [7:0] sel_nxt   = (sync_lock && ok_w[sel_r[$clog2(N_IN)-1:0]])
                         ? sel_r : pick[7:0];               // RULE_21
    wire       any_ok    = pick[8];
    wire       bypass    = (clk_unit_ok_in == 2'b00);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sel_r      <= 8'h00;
            ref_ok_r   <= 1'b0;
            was_lost_r <= 1'b1;
        end else begin
            ref_ok_r <= any_ok;
            if (any_ok) begin
                sel_r <= sel_nxt;                           // RULE_05
            end
            // sel_r kept while lost: outputs free-run on holdover
            was_lost_r <= ~any_ok;                          // RULE_06
        end
    end

    // ****************************************************************
    // phase alignment and 4 kHz clock
    // ****************************************************************
    wire [$clog2(N_IN)-1:0] si = sel_r[$clog2(N_IN)-1:0];
    wire sel_evt  = ref_ok_r && evt_w[si];
    wire realign  = any_ok && was_lost_r;                   // RULE_07

    // alignment re-derived on each marker so no error builds up
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            align_r <= 1'b0;
            c4k_r   <= 1'b0;
        end else begin
            align_r <= sel_evt | realign;                   // RULE_11 RULE_17
            if (sel_evt) begin
                c4k_r <= ~c4k_r;                            // RULE_12
            end
        end
    end

    // ****************************************************************
    // frequency steering and holdover
    // ****************************************************************
    wire signed [16:0] perr = $signed({1'b0, ph_w[si]}) -
                              $signed({1'b0, osc_phase_in});
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ferr_r <= 17'sh00000;
            hold_r <= 17'sh00000;
        end else if (ref_ok_r && sel_evt) begin
            ferr_r <= perr;                                 // RULE_13
            hold_r <= hold_r + ((perr - hold_r) >>> 4);
        end else if (!ref_ok_r) begin
            ferr_r <= hold_r;                               // RULE_06
        end
    end

    // ****************************************************************
    // secondary alignment check
    // ****************************************************************
    function automatic logic far_off(input logic [15:0] a,
                                     input logic [15:0] b);
        logic [15:0] d;
        d = (a > b) ? a - b : b - a;
        return d > 16'(`SRS_ALIGN_TOL);
    endfunction : far_off

    // an aligned secondary has counted as many cycles since its last
    // marker as the selected input has at the selected marker
    logic warn_w;
    always_comb begin
        warn_w = 1'b0;
        for (int i = 0; i < N_IN; i++) begin
            if (ok_w[i] && (8'(i) != sel_r) && ref_ok_r &&
                evt_w[si] && far_off(ph_w[i], ph_w[si])) begin
                warn_w = 1'b1;                              // RULE_14
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            warn_r <= 1'b0;
        end else if (sel_evt) begin
            warn_r <= warn_w;
        end
    end

    // ****************************************************************
    // mode command
    // ****************************************************************
    wire to_sub   = mode_arg_in &&
                    (mode_val_in != srs_pkg::SRS_MODE_NORMAL);
    wire mode_bad = mode_cmd_in && to_sub && !any_ok;       // RULE_15
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            mode_r <= srs_pkg::SRS_MODE_NORMAL;
            rpt_r  <= 1'b0;
            rej_r  <= 1'b0;
        end else begin
            rpt_r <= mode_cmd_in && !mode_arg_in;           // RULE_19
            rej_r <= mode_bad;
            // no output squelch: a mode change may glitch the phase
            if (mode_cmd_in && mode_arg_in && !mode_bad && !sync_lock) begin
                mode_r <= mode_val_in;                      // RULE_22
            end
        end
    end

    // ****************************************************************
    // ds1 monitoring
    // ****************************************************************
    always_ff @(posedge core_clk_in) begin
        ds_s_r <= {ds_s_r[1:0], ds1_in};
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ds_r <= 1'b0;
        end else begin
            ds_r <= ds_s_r[1] ^ ds_s_r[2];                  // RULE_03
        end
    end

    // ****************************************************************
    // phase step sync
    // ****************************************************************
    wire [3:0] steps = (sync_steps_in == 4'h0) ? `SRS_STEP_DEF
                     : sync_steps_in;
    wire sync_ok = is_sub && (steps <= `SRS_STEP_MAX);      // RULE_20
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sy_r      <= SRS_SY_IDLE;
            sy_left_r <= 4'h0;
            step_r    <= 1'b0;
            srej_r    <= 1'b0;
            off_r     <= 16'h0000;
        end else begin
            step_r <= 1'b0;
            srej_r <= 1'b0;
            case (sy_r)
                SRS_SY_IDLE: begin
                    if (sync_cmd_in && sync_ok) begin
                        sy_r      <= SRS_SY_STEP;
                        sy_left_r <= steps;
                    end else if (sync_cmd_in) begin
                        srej_r <= 1'b1;                     // RULE_21
                    end
                end
                SRS_SY_STEP: begin
                    if (sync_abort_in) begin
                        sy_r <= SRS_SY_ASK;                 // RULE_21
                    end else if (sy_left_r == 4'h0) begin
                        sy_r <= SRS_SY_IDLE;
                    end else if (sel_evt) begin
                        step_r    <= 1'b1;
                        sy_left_r <= sy_left_r - 4'h1;
                        off_r     <= off_r + 16'(`SRS_STEP_NS); // RULE_20
                    end
                end
                SRS_SY_ASK: begin
                    if (sync_stay_in) begin
                        sy_r <= SRS_SY_STEP;
                    end else if (sync_abort_in) begin
                        sy_r <= SRS_SY_IDLE;
                    end
                end
                default: sy_r <= SRS_SY_IDLE;
            endcase
        end
    end

    assign mode_out       = mode_r;
    assign mode_rpt_out   = rpt_r;
    assign mode_rej_out   = rej_r;
    assign sel_out        = sel_r;
    assign ref_ok_out     = ref_ok_r;
    assign src_out        = bypass ? srs_pkg::SRS_SRC_BYPASS
                          : ref_ok_r ? srs_pkg::SRS_SRC_LOCKED
                          : srs_pkg::SRS_SRC_HOLDOVER;      // RULE_06 RULE_18
    assign bypass_clk_out = bypass && ref_ok_r && cc_in[si]; // RULE_18
    assign align_out      = align_r;
    assign clk4k_out      = c4k_r;
    assign freq_err_out   = ferr_r;
    assign holdover_out   = hold_r;
    assign phase_warn_out = warn_r;
    assign ds1_mon_out    = ds_r;
    assign sync_busy_out  = sync_lock;
    assign sync_ask_out   = (sy_r == SRS_SY_ASK);
    assign step_pulse_out = step_r;
    assign sync_rej_out   = srej_r;
    assign offset_ns_out  = off_r;

    a_sel_valid : assert property (@(posedge core_clk_in) disable iff (rst_in)
        ref_ok_r && !sync_lock |-> ok_w[si] || !any_ok || $changed(ok_w))
        else $error("active reference is not valid"); // RULE_04
    a_recover : assert property (@(posedge core_clk_in) disable iff (rst_in)
        !ref_ok_r ##1 ref_ok_r |-> align_r)  // RULE_07
        else $error("no realign after recovery");
    a_mode_rej : assert property (@(posedge core_clk_in) disable iff (rst_in)
        mode_bad |=> mode_rej_out && $stable(mode_r))  // RULE_15
        else $error("subtending start without reference");
    a_mode_rpt : assert property (@(posedge core_clk_in) disable iff (rst_in)
        mode_cmd_in && !mode_arg_in |=> mode_rpt_out && $stable(mode_r))
        else $error("bare mode command changed mode"); // RULE_19
    a_sync_rej : assert property (@(posedge core_clk_in) disable iff (rst_in)
        sync_cmd_in && !is_sub && !sync_lock |=> sync_rej_out && !sync_lock)
        else $error("sync accepted outside subtending"); // RULE_21
    a_step_size : assert property (@(posedge core_clk_in) disable iff (rst_in)
        step_r |-> off_r == $past(off_r) + 16'h0064)  // RULE_20
        else $error("step not 100 ns");
    a_bypass : assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_unit_ok_in == 2'b00 |-> src_out == srs_pkg::SRS_SRC_BYPASS)
        else $error("no bypass with both units down"); // RULE_18
    a_holdover : assert property (@(posedge core_clk_in) disable iff (rst_in)
        !ref_ok_r ##1 !ref_ok_r |-> ferr_r == hold_r && !align_r)
        else $error("holdover not used"); // RULE_06
endmodule : srs_ref_selector

// file: shared/srs_map.svh
// constants for the subtending reference selector
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
`define SRS_CLK_HZ          100000000
`define SRS_BPV_NOM_PER_S   8000
`define SRS_BPV_TOL_PCT     10
`define SRS_CC_HZ           64000
`define SRS_STEP_NS         100
`define SRS_STEP_MAX        4'hA
`define SRS_STEP_DEF        4'h1
`define SRS_LOS_PERIODS     16
`define SRS_ALIGN_TOL       16
`endif

// file: shared/srs_pkg.sv
// types for the subtending reference selector
package srs_pkg;
    typedef enum logic [1:0] {
        SRS_MODE_NORMAL,
        SRS_MODE_SUB,
        SRS_MODE_JAPAN
    } srs_mode_t;
    typedef enum logic [1:0] {
        SRS_SRC_LOCKED,
        SRS_SRC_HOLDOVER,
        SRS_SRC_BYPASS
    } srs_src_t;
endpackage : srs_pkg

// file: src/srs_input_mon.sv
// per-input monitor: loss of signal and violation rate check
`timescale 1ns/1ps
`include "srs_map.svh"
module srs_input_mon #(
    parameter int CLK_HZ = `SRS_CLK_HZ
) (
    input  wire logic        core_clk_in,   // core clock
    input  wire logic        rst_in,        // sync reset
    input  wire logic        cc_in,         // composite clock pin
    input  wire logic        bpv_in,        // violation marker pin
    output logic             valid_out,     // input judged valid
    output logic             los_out,       // loss of signal
    output logic             bpv_bad_out,   // rate out of tolerance
    output logic             bpv_evt_out,   // violation edge pulse
    output logic [15:0]      bpv_phase_out  // count since last marker
);
    localparam int LOS_CYC = (CLK_HZ / `SRS_CC_HZ) * `SRS_LOS_PERIODS;
    localparam int BPV_LO  = `SRS_BPV_NOM_PER_S
                           * (100 - `SRS_BPV_TOL_PCT) / 100;
    localparam int BPV_HI  = `SRS_BPV_NOM_PER_S
                           * (100 + `SRS_BPV_TOL_PCT) / 100;
    localparam int SEC_CYC = CLK_HZ;

    logic [2:0]  cc_s_r;
    logic [2:0]  bv_s_r;
    logic [15:0] los_cnt_r;
    logic [31:0] sec_cnt_r;
    logic [15:0] bpv_cnt_r;
    logic        bpv_bad_r;
    logic [15:0] ph_r;
    wire         cc_edge;
    wire         bv_edge;
    wire         sec_end;

    // stage 0 feeds only stage 1
    assign cc_edge = cc_s_r[1] & ~cc_s_r[2];
    assign bv_edge = bv_s_r[1] & ~bv_s_r[2];
    assign sec_end = (sec_cnt_r == 32'(SEC_CYC - 1));

    always_ff @(posedge core_clk_in) begin
        cc_s_r <= {cc_s_r[1:0], cc_in};
        bv_s_r <= {bv_s_r[1:0], bpv_in};
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            los_cnt_r <= 16'h0000;
            sec_cnt_r <= 32'h0000_0000;
            bpv_cnt_r <= 16'h0000;
            bpv_bad_r <= 1'b1;
            ph_r      <= 16'h0000;
        end else begin
            if (cc_edge) begin
                los_cnt_r <= 16'h0000;
            end else if (los_cnt_r != 16'(LOS_CYC)) begin
                los_cnt_r <= los_cnt_r + 16'h0001;  // RULE_09
            end
            sec_cnt_r <= sec_end ? 32'h0000_0000 : sec_cnt_r + 32'h1;
            if (sec_end) begin
                bpv_cnt_r <= 16'h0000;
                bpv_bad_r <= (bpv_cnt_r < 16'(BPV_LO)) ||
                             (bpv_cnt_r > 16'(BPV_HI));  // RULE_10
            end else if (bv_edge) begin
                bpv_cnt_r <= bpv_cnt_r + 16'h0001;
            end
            ph_r <= bv_edge ? 16'h0000 : ph_r + 16'h0001;
        end
    end

    assign los_out       = (los_cnt_r == 16'(LOS_CYC));
    assign bpv_bad_out   = bpv_bad_r;
    assign valid_out     = ~los_out & ~bpv_bad_r;  // RULE_08
    assign bpv_evt_out   = bv_edge;
    assign bpv_phase_out = ph_r;

    a_los_valid : assert property (@(posedge core_clk_in) disable iff (rst_in)
        los_out |-> !valid_out)  // RULE_08
        else $error("valid while in loss of signal");
    a_los_clear : assert property (@(posedge core_clk_in) disable iff (rst_in)
        cc_edge |=> !los_out)  // RULE_09
        else $error("loss not cleared by clock edge");
endmodule : srs_input_mon

// file: bench/srs_master_model.sv
// master shelf model: composite clock and violation markers per input
`timescale 1ns/1ps
module srs_master_model (
    input  wire logic [1:0] alive_in, // source running, per input
    output logic      [1:0] cc_out,   // composite clock, 80 ns period
    output logic      [1:0] bpv_out   // marker rising every 80 ns
);
    logic link_clk = 1'h0;
    // own time base, phase unrelated to the core clock
    initial begin
        #3;
        forever begin
            #40 link_clk = ~link_clk;
        end
    end
    // a dead source sits low, so no edge is left to track
    // one marker a period keeps the scaled rate window short
    assign cc_out  = alive_in & {2{link_clk}};
    assign bpv_out = alive_in & {2{link_clk}};
endmodule : srs_master_model

// file: bench/srs_ref_selector_test.sv
// self-checking bench for the subtending reference selector
`timescale 1ns/1ps
module srs_ref_selector_test;
    // 0.64 ms rate window, loss after 16 cycles; markers give 8000/window
    localparam int CLK_HZ = 64000;
    logic clk = 1'h0, rst = 1'h1, cmd = 1'h0, arg = 1'h0, scmd = 1'h0;
    logic ds1 = 1'h0, jm = 1'h0, rpt, srej, ok, busy, rej, algn, warn, stp;
    logic [1:0] cc, bipolar_violation_marker, jp = 2'h0, ucok = 2'h3, alive = 2'h3;
    logic [3:0] steps = 4'h0;
    logic [7:0] sel;
    logic [15:0] osc = 16'h0000, offs;
    srs_pkg::srs_mode_t mval = srs_pkg::SRS_MODE_NORMAL, mode_o;
    srs_pkg::srs_src_t  src;
    int num_errors = 0, checked = 0, exp_off = 0, seed = 32'h15F109FC;
    int nstep = 0;

    srs_master_model i_master (.alive_in(alive), .cc_out(cc), .bpv_out(bipolar_violation_marker));
    srs_ref_selector #(.N_IN(2), .CLK_HZ(CLK_HZ)) i_dut (
        .core_clk_in(clk), .rst_in(rst), .cc_in(cc), .bpv_in(bipolar_violation_marker),
        .is_japan_in(jp), .ds1_in(ds1), .mode_cmd_in(cmd),
        .mode_arg_in(arg), .mode_val_in(mval), .manual_in(1'h0),
        .manual_sel_in(8'h00), .clk_unit_ok_in(ucok), .osc_phase_in(osc),
        .sync_cmd_in(scmd), .sync_steps_in(steps), .sync_abort_in(1'h0),
        .sync_stay_in(1'h0), .mode_out(mode_o), .mode_rpt_out(rpt),
        .mode_rej_out(rej), .sel_out(sel), .ref_ok_out(ok), .src_out(src),
        .align_out(algn), .clk4k_out(), .bypass_clk_out(), .freq_err_out(),
        .holdover_out(), .phase_warn_out(warn), .ds1_mon_out(),
        .sync_busy_out(busy), .sync_ask_out(), .step_pulse_out(stp),
        .sync_rej_out(srej), .offset_ns_out(offs));

    initial begin
        forever begin
            #5 clk = ~clk;
        end
    end
    always @(negedge clk) begin
        osc <= $random(seed);
        ds1 <= $random(seed);
        if (stp === 1'h1) nstep <= nstep + 1;
    end

    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // model: first running, eligible input wins; -1 when none is left
    function automatic int best(input logic [1:0] m);
        for (int i = 0; i < 2; i++) if (m[i]) return i;
        return -1;
    endfunction : best
    task automatic cmd_mode(input logic a, input srs_pkg::srs_mode_t v);
        @(negedge clk);
        cmd  = 1'h1;
        arg  = a;
        mval = v;
        @(negedge clk);
        cmd = 1'h0;
    endtask : cmd_mode
    task automatic run_sync(input logic [3:0] n, input logic refuse);
        int k, n0;
        @(negedge clk);
        scmd  = 1'h1;
        steps = n;
        @(negedge clk);
        scmd = 1'h0;
        n0   = nstep;
        chk(srej, refuse);
        if (!refuse) exp_off += 100 * ((n == 0) ? 1 : n);
        for (k = 0; k < 600 && busy !== 1'h0; k++) @(negedge clk);
        if (k == 600) begin num_errors++; close_out(); end
        chk(offs, exp_off);
        chk(nstep - n0, refuse ? 0 : ((n == 0) ? 1 : n));
    endtask : run_sync
    task automatic wait_ref;
        int k, e;
        e = best(alive & (jm ? jp : ~jp));
        for (k = 0; k < 70000; k++) begin
            @(negedge clk);
            if (ok === (e >= 0) && (e < 0 || sel === e[7:0])) break;
        end
        if (k == 70000) begin num_errors++; close_out(); end
        chk(ok, e >= 0);
        if (e >= 0) chk(sel, e[7:0]);
    endtask : wait_ref

    initial begin
        repeat (16) @(negedge clk);
        chk(ok, 1'h0);
        chk(src, srs_pkg::SRS_SRC_HOLDOVER);
        chk(offs, 16'h0000);
        rst = 1'h0;
        cmd_mode(1'h0, srs_pkg::SRS_MODE_SUB);
        chk(rpt, 1'h1);
        chk(mode_o, srs_pkg::SRS_MODE_NORMAL);
        run_sync(4'h1, 1'h1);
        $display("reset, report and refusal done");
        wait_ref();
        cmd_mode(1'h1, srs_pkg::SRS_MODE_SUB);
        chk(mode_o, srs_pkg::SRS_MODE_SUB);
        run_sync(4'h0, 1'h0);
        run_sync(4'hA, 1'h0);
        run_sync(4'hB, 1'h1);
        chk(warn, 1'h0);
        $display("subtending mode and step sync done");
        jp = 2'h1;
        wait_ref();
        jp = 2'h0;
        wait_ref();
        ucok = 2'h0;
        @(negedge clk);
        chk(src, srs_pkg::SRS_SRC_BYPASS);
        ucok = 2'h3;
        $display("eligibility and bypass done");
        alive = 2'h2;
        wait_ref();
        alive = 2'h0;
        wait_ref();
        chk(src, srs_pkg::SRS_SRC_HOLDOVER);
        alive = 2'h3;
        wait_ref();
        chk(algn, 1'h1);
        $display("switchover, holdover and recovery done");
        jp = 2'h2;
        jm = 1'h1;
        cmd_mode(1'h1, srs_pkg::SRS_MODE_JAPAN);
        chk(mode_o, srs_pkg::SRS_MODE_JAPAN);
        wait_ref();
        alive = 2'h0;
        wait_ref();
        cmd_mode(1'h1, srs_pkg::SRS_MODE_SUB);
        chk(rej, 1'h1);
        chk(mode_o, srs_pkg::SRS_MODE_JAPAN);
        $display("japan mode and refused start done");
        close_out();
    end
endmodule : srs_ref_selector_test
